// File: include/burst_cfg_pkg.sv
// Shared constants and types for the synchronous burst engine.
// Assumes a single 100 MHz clock domain and a synchronous reset.
package burst_cfg_pkg;

  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 23;

  // Configuration word field positions
  localparam int unsigned BL_LSB    = 0;
  localparam int unsigned WRAP_BIT  = 3;
  localparam int unsigned DRV_LSB   = 4;
  localparam int unsigned WCFG_BIT  = 8;
  localparam int unsigned WPOL_BIT  = 10;
  localparam int unsigned LAT_LSB   = 11;
  localparam int unsigned FIXED_BIT = 14;
  localparam int unsigned MODE_BIT  = 15;

  // Power-up value of the configuration word
  localparam logic [15:0] BUS_CFG_RESET = 16'h9D1F;

  // Burst length codes
  localparam logic [2:0] BL_4    = 3'h1;
  localparam logic [2:0] BL_8    = 3'h2;
  localparam logic [2:0] BL_16   = 3'h3;
  localparam logic [2:0] BL_32   = 3'h4;
  localparam logic [2:0] BL_CONT = 3'h7;

  // Drive strength codes
  localparam logic [1:0] DRV_FULL    = 2'h0;
  localparam logic [1:0] DRV_HALF    = 2'h1;
  localparam logic [1:0] DRV_QUARTER = 2'h2;

  // Latency code 0 means eight clocks
  localparam logic [3:0] LAT_CODE0 = 4'h8;
  // Extra cycles added when a refresh collides in variable mode
  localparam logic [3:0] REFRESH_PENALTY = 4'h3;

  localparam int unsigned FIFO_DEPTH = 4;

  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
  } burst_req_s;

  typedef struct packed {
    logic [1:0] drive;
    logic       wait_lvl;
  } pin_cfg_s;

endpackage : burst_cfg_pkg

// File: logic/word_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module word_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 4
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready = (count != (PW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign push     = in_valid && in_ready;
  assign pop      = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
      end
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // Registered read port: head word is presented from a flop
  always_ff @(posedge clk) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (!out_valid || out_ready) begin
      out_valid <= (count > (PW+1)'(pop)) || push;
      if (count > (PW+1)'(pop)) begin
        out_data <= mem[pop ? ((rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1)) : rd_ptr];
      end else begin
        out_data <= in_data;
      end
    end
  end

  a_fifo_no_over : assert property (@(posedge clk) disable iff (rst)
    (count == (PW+1)'(DEPTH)) |-> !in_ready)
    else $error("fifo accepted a word while full");

endmodule : word_fifo

// File: logic/burst_engine.sv
// Synchronous burst sequencer: address stepping, latency, WAIT timing.
// Assumes the host starts a burst with a one-cycle start pulse and
// supplies array data through the read FIFO; one clock, sync reset.
//
// Functional notes
// R1: Wrap mode steps within aligned burst block
// R2: No wrap: linear, roll over past top
// R3: Lengths 4, 8, 16, 32 and continuous
// R4: Drive field selects full, half, quarter
// R5: Config 0: data follows WAIT by one; the code changes WAIT together with the data edge
// R6: Config 1: WAIT leads data by one
// R7: Reset default: WAIT leads data
// R8: Polarity bit sets WAIT asserted level
// R9: Host paces transfers by watching WAIT
// R10: Latency field sets clocks to first data
// R11: Latency mode bit, variable by default
// R12: Variable latency stretches on refresh collision
// R13: Fixed latency starts after exact count
// R14: Host picks count matching clock frequency
// R15: Mode bit selects sync burst or async
`timescale 1ns/1ps
module burst_engine
  import burst_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // Configuration write port
  input  wire logic                          cfg_we,
  input  wire logic [15:0]                   cfg_wdata,
  output logic      [15:0]                   bus_configuration,
  // Burst request from the bus front end
  input  wire logic                          start,
  input  wire burst_cfg_pkg::burst_req_s     req,
  input  wire logic                          stop,
  input  wire logic                          refresh_busy,
  // Array side: read data enters the FIFO
  input  wire logic                          arr_valid,
  output logic                               arr_ready,
  input  wire logic [burst_cfg_pkg::DATA_W-1:0] arr_data,
  // Pin side
  output logic      [burst_cfg_pkg::ADDR_W-1:0] word_addr,
  output logic                               data_valid,
  output logic      [burst_cfg_pkg::DATA_W-1:0] dq_out,
  output logic                               dq_oe,
  output logic                               wait_out,
  output burst_cfg_pkg::pin_cfg_s            pin_cfg,
  output logic                               sync_mode
);
  import burst_cfg_pkg::*;

  typedef enum logic [1:0] {
    IDLE    = 2'b00,
    LATENCY = 2'b01,
    XFER    = 2'b10
  } phase_e;

  phase_e            phase;
  logic [3:0]        lat_cnt;
  logic [5:0]        beat_cnt;
  logic              is_write;
  logic              busy_wait;
  logic              next_busy;
  logic [ADDR_W-1:0] next_addr;
  logic [5:0]        blen;
  logic              f_valid;
  logic              f_ready;
  logic [DATA_W-1:0] f_data;
  logic [3:0]        lat_clks;
  logic              collided;
  logic              stretched;
  logic              rd_stage;
  logic [DATA_W-1:0] rd_word;

  word_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (arr_valid),
    .in_ready  (arr_ready),
    .in_data   (arr_data),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      bus_configuration <= BUS_CFG_RESET; // R7 R11 R15
    end else if (cfg_we && phase == IDLE) begin
      bus_configuration <= cfg_wdata;
    end
  end

  always_comb begin
    unique case (bus_configuration[BL_LSB +: 3]) // R3
      BL_4:    blen = 6'h04;
      BL_8:    blen = 6'h08;
      BL_16:   blen = 6'h10;
      BL_32:   blen = 6'h20;
      default: blen = 6'h00;
    endcase
  end

  // Latency code to clocks; code 0 gives eight
  assign lat_clks = (bus_configuration[LAT_LSB +: 3] == 3'h0) ? LAT_CODE0 :
                    {1'b0, bus_configuration[LAT_LSB +: 3]}; // R10

  // Address stepping: wrap inside the aligned block or run linear
  always_comb begin
    next_addr = word_addr + ADDR_W'(1); // R2
    if (!bus_configuration[WRAP_BIT] && blen != 6'h00) begin
      next_addr = (word_addr & ~(ADDR_W'(blen) - ADDR_W'(1)))
                | ((word_addr + ADDR_W'(1)) & (ADDR_W'(blen) - ADDR_W'(1))); // R1
    end
  end

  // Data is held off while in latency or while the FIFO has nothing
  assign f_ready   = (phase == XFER) && !is_write && f_valid && !stop;
  assign collided  = refresh_busy && !bus_configuration[FIXED_BIT];
  assign next_busy = (phase == LATENCY) || (phase == XFER && !is_write && !f_valid);

  always_ff @(posedge clk) begin
    if (rst) begin
      phase     <= IDLE;
      lat_cnt   <= '0;
      beat_cnt  <= '0;
      is_write  <= 1'b0;
      word_addr <= '0;
      stretched <= 1'b0;
    end else begin
      unique case (phase)
        IDLE: begin
          if (start && bus_configuration[MODE_BIT] == 1'b0) begin // R15
            phase     <= LATENCY;
            is_write  <= req.write;
            word_addr <= req.addr;
            lat_cnt   <= lat_clks - 4'h1;
            beat_cnt  <= '0;
            stretched <= 1'b0;
          end
        end
        LATENCY: begin
          // One stretch per burst, so a long refresh cannot stall forever
          if (collided && !stretched && lat_cnt == 4'h1) begin
            lat_cnt   <= REFRESH_PENALTY; // R12
            stretched <= 1'b1;
          end else if (lat_cnt == 4'h0) begin
            phase <= XFER; // R13
          end else begin
            lat_cnt <= lat_cnt - 4'h1;
          end
        end
        XFER: begin
          if (stop) begin
            phase <= IDLE;
          end else if (is_write || f_valid) begin
            word_addr <= next_addr;
            beat_cnt  <= beat_cnt + 6'h01;
            if (blen != 6'h00 && beat_cnt == blen - 6'h01) begin
              phase <= IDLE;
            end
          end
        end
        default: phase <= IDLE;
      endcase
    end
  end

  // Data pins: read words pass one staging flop so WAIT can lead them
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_stage   <= 1'b0;
      rd_word    <= '0;
      data_valid <= 1'b0;
      dq_out     <= '0;
      dq_oe      <= 1'b0;
    end else begin
      rd_stage   <= f_ready; // R5 R6
      data_valid <= rd_stage;
      dq_oe      <= rd_stage || ((phase == XFER) && !is_write && !stop);
      if (f_ready) begin
        rd_word <= f_data;
      end
      if (rd_stage) begin
        dq_out <= rd_word;
      end
    end
  end

  // WAIT: config 1 shows the busy term one clock ahead of data,
  // config 0 delays it so it changes together with the data edge
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_wait <= 1'b0;
    end else begin
      busy_wait <= next_busy;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wait_out <= BUS_CFG_RESET[WPOL_BIT] ? 1'b0 : 1'b1;
    end else if (bus_configuration[WCFG_BIT]) begin
      wait_out <= next_busy ~^ bus_configuration[WPOL_BIT]; // R6 R8 R9
    end else begin
      wait_out <= busy_wait ~^ bus_configuration[WPOL_BIT]; // R5 R8
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_cfg   <= '{drive: DRV_HALF, wait_lvl: 1'b1};
      sync_mode <= 1'b0;
    end else begin
      pin_cfg.drive    <= (bus_configuration[DRV_LSB +: 2] == 2'h3) ? DRV_HALF :
                          bus_configuration[DRV_LSB +: 2]; // R4
      pin_cfg.wait_lvl <= bus_configuration[WPOL_BIT];
      sync_mode        <= !bus_configuration[MODE_BIT];
    end
  end

  a_reset_defaults : assert property (@(posedge clk)
    rst |=> bus_configuration == BUS_CFG_RESET) // R7
    else $error("configuration not at power-up value");
  a_async_no_burst : assert property (@(posedge clk) disable iff (rst)
    (phase == IDLE && start && bus_configuration[MODE_BIT]) |=> phase == IDLE) // R15
    else $error("burst started in asynchronous mode");
  a_fixed_latency : assert property (@(posedge clk) disable iff (rst)
    (phase == IDLE && start && !bus_configuration[MODE_BIT] && bus_configuration[FIXED_BIT]
     && bus_configuration[LAT_LSB +: 3] == 3'h3 && !cfg_we)
    |=> phase == LATENCY [*3] ##1 phase == XFER) // R13 R10
    else $error("fixed latency not exact");
  a_wrap_step : assert property (@(posedge clk) disable iff (rst)
    (phase == XFER && !stop && is_write && !bus_configuration[WRAP_BIT]
     && bus_configuration[BL_LSB +: 3] == BL_4 && word_addr[1:0] == 2'h3)
    |=> word_addr[1:0] == 2'h0 && word_addr[ADDR_W-1:2] == $past(word_addr[ADDR_W-1:2])) // R1
    else $error("wrap left the aligned block");
  a_linear_step : assert property (@(posedge clk) disable iff (rst)
    (phase == XFER && !stop && is_write && bus_configuration[WRAP_BIT])
    |=> word_addr == $past(word_addr) + ADDR_W'(1)) // R2
    else $error("linear step wrong");
  a_burst_len : assert property (@(posedge clk) disable iff (rst)
    (phase == XFER && is_write && !stop && bus_configuration[BL_LSB +: 3] == BL_4
     && beat_cnt == 6'h03) |=> phase == IDLE) // R3
    else $error("four-word burst did not end");
  a_wait_leads : assert property (@(posedge clk) disable iff (rst)
    (bus_configuration[WCFG_BIT] && $stable(bus_configuration) && rd_stage)
    |-> wait_out != bus_configuration[WPOL_BIT]) // R6
    else $error("wait asserted one clock before data");
  a_wait_follows : assert property (@(posedge clk) disable iff (rst)
    (!bus_configuration[WCFG_BIT] && $stable(bus_configuration) && data_valid)
    |-> wait_out != bus_configuration[WPOL_BIT]) // R5
    else $error("wait asserted alongside valid data");
  a_drive_map : assert property (@(posedge clk) disable iff (rst)
    $stable(bus_configuration) && bus_configuration[DRV_LSB +: 2] == DRV_QUARTER
    |=> pin_cfg.drive == DRV_QUARTER) // R4
    else $error("drive strength not applied");
  a_wait_latency : assert property (@(posedge clk) disable iff (rst) // R12
    (phase == LATENCY && bus_configuration[WCFG_BIT] && $stable(bus_configuration))
    |=> wait_out == bus_configuration[WPOL_BIT]) // R8
    else $error("wait not asserted during latency");
  a_mode_flag : assert property (@(posedge clk) disable iff (rst) // R15
    $stable(bus_configuration) |-> sync_mode != bus_configuration[MODE_BIT])
    else $error("sync mode flag does not follow mode bit");

  c_read_burst  : cover property (@(posedge clk) disable iff (rst) data_valid [*4]);
  c_collision   : cover property (@(posedge clk) disable iff (rst) phase == LATENCY && collided);
  c_write_burst : cover property (@(posedge clk) disable iff (rst) phase == XFER && is_write);
  c_wait_low    : cover property (@(posedge clk) disable iff (rst)
    !bus_configuration[WPOL_BIT] && data_valid);

endmodule : burst_engine

// File: test/host_model.sv
// Host controller stand-in: pulses start with a request and times WAIT and data.
// Assumes the bench raises go for one cycle per burst; one clock, sync reset.
`timescale 1ns/1ps
module host_model
  import burst_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst,
  // Bench command
  input  wire logic                      go,
  input  wire burst_cfg_pkg::burst_req_s go_req,
  // Device pins
  input  wire logic                      wait_out,
  input  wire logic                      wait_pol,
  input  wire logic                      data_valid,
  output logic                           start,
  output burst_cfg_pkg::burst_req_s      req,
  // Cycles from start to WAIT release and first data
  output int                             t_wait,
  output int                             t_data
);
  int   cnt;
  logic seen;

  // Request lines carry the inverted request outside the start cycle
  always_ff @(posedge clk) begin
    start <= go && !rst;
    req   <= go ? go_req : ~go_req;
  end

  // Times the burst by watching WAIT and data_valid, counting from the cycle after go
  always_ff @(posedge clk) begin
    if (rst || go) begin
      cnt    <= 0;
      seen   <= 1'b0;
      t_wait <= -1;
      t_data <= -1;
    end else begin
      cnt <= cnt + 1;
      if (wait_out === wait_pol) seen <= 1'b1;
      if (seen && t_wait < 0 && wait_out === !wait_pol) t_wait <= cnt;
      if (t_data < 0 && data_valid === 1'b1) t_data <= cnt;
    end
  end
endmodule : host_model

// File: test/tb.sv
// Self-checking bench for the burst engine: address order, latency, WAIT timing.
// Assumes the host model drives start and req; the bench feeds the read FIFO.
`timescale 1ns/1ps
module tb;
  import burst_cfg_pkg::*;
  logic              clk = 0, rst = 1, cfg_we = 0, stop = 0, refresh_busy = 0;
  logic              arr_valid = 0, go = 0, start, arr_ready, data_valid, dq_oe;
  logic              wait_out, sync_mode;
  logic [15:0]       cfg_wdata = 16'h0000, arr_data = 16'h0000, bus_configuration, dq_out;
  logic [ADDR_W-1:0] word_addr;
  logic [22:0]       got [4];
  logic [15:0]       dq [4];
  pin_cfg_s          pin_cfg;
  burst_req_s        req, hreq = '0;
  int                failures = 0, checked = 0, t_wait, t_data, n, nd, ts, t2, d0;
  // Columns: config, start, three following addresses, expected drive
  logic [23:0]       rows [6][6] = '{
    '{24'h5D01, 24'h000001, 24'h2, 24'h3, 24'h0, 24'h0},
    '{24'h5D12, 24'h00000E, 24'hF, 24'h8, 24'h9, 24'h1},
    '{24'h5D29, 24'h000003, 24'h4, 24'h5, 24'h6, 24'h2},
    '{24'h5D3F, 24'h7FFFFE, 24'h7FFFFF, 24'h0, 24'h1, 24'h1},
    '{24'h5D13, 24'h00001E, 24'h1F, 24'h10, 24'h11, 24'h1},
    '{24'h5D14, 24'h00003F, 24'h20, 24'h21, 24'h22, 24'h1}};

  always #5 clk = ~clk;

  burst_engine u_burst_engine (.clk(clk), .rst(rst), .cfg_we(cfg_we), .cfg_wdata(cfg_wdata),
    .bus_configuration(bus_configuration), .start(start), .req(req), .stop(stop),
    .refresh_busy(refresh_busy), .arr_valid(arr_valid), .arr_ready(arr_ready),
    .arr_data(arr_data), .word_addr(word_addr), .data_valid(data_valid), .dq_out(dq_out),
    .dq_oe(dq_oe), .wait_out(wait_out), .pin_cfg(pin_cfg), .sync_mode(sync_mode));

  host_model u_host_model (.clk(clk), .rst(rst), .go(go), .go_req(hreq),
    .wait_out(wait_out), .wait_pol(bus_configuration[WPOL_BIT]), .data_valid(data_valid),
    .start(start), .req(req), .t_wait(t_wait), .t_data(t_data));

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  // One burst: load config, start, log addresses and read words, then stop
  task automatic burst(input logic [15:0] cfg, input logic [22:0] a, input logic wr);
    logic on;
    cfg_wdata <= cfg;
    cfg_we    <= 1'b1;
    @(posedge clk);
    cfg_we <= 1'b0;
    @(posedge clk);
    hreq <= '{write: wr, addr: a};
    go   <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    n = 0; nd = 0; ts = -1; on = 0;
    for (int i = 0; i < 60; i++) begin
      @(posedge clk);
      if (i == 0) begin
        cfg_wdata <= 16'h0000;
        cfg_we    <= 1'b1;
      end else if (i == 1) cfg_we <= 1'b0;
      #1;
      if (word_addr === a) on = 1;
      if (on && n < 4 && (n == 0 || word_addr !== got[n-1])) begin
        got[n] = word_addr;
        n++;
        if (n == 2) ts = i;
      end
      if (data_valid === 1'b1 && nd < 4) begin
        dq[nd] = dq_out;
        nd++;
        chk(dq_oe, 1'b1);
      end
    end
    @(posedge clk);
    stop <= 1'b1;
    @(posedge clk);
    stop <= 1'b0;
    repeat (4) @(posedge clk);
    chk(bus_configuration, cfg);
  endtask : burst

  initial begin
    #100000;
    failures++;
    wrap_up();
  end

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk(bus_configuration, 16'h9D1F);
    chk(pin_cfg.drive, DRV_HALF);
    chk(wait_out, 1'b0);
    chk(sync_mode, 1'b0);
    @(posedge clk);
    hreq <= '{write: 1'b1, addr: 23'h5};
    go   <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (10) @(posedge clk);
    chk(word_addr, 23'h0);
    for (int r = 0; r < 6; r++) begin
      burst(rows[r][0][15:0], rows[r][1][22:0], 1'b1);
      chk(n, 4);
      for (int k = 1; k < 4; k++) chk(got[k], rows[r][k+1]);
      chk(pin_cfg.drive, rows[r][5][1:0]);
      chk(sync_mode, 1'b1);
    end
    burst(16'h5509, 23'h100, 1'b1);
    t2 = ts;
    burst(16'h7509, 23'h100, 1'b1);
    chk(ts - t2, 4);
    burst(16'h4509, 23'h100, 1'b1);
    chk(ts - t2, 6);
    burst(16'h1D09, 23'h100, 1'b1);
    chk(ts - t2, 1);
    refresh_busy <= 1'b1;
    burst(16'h1D09, 23'h100, 1'b1);
    chk(ts - t2, 4);
    refresh_busy <= 1'b0;
    // Read bursts drain a full FIFO; WAIT timing and polarity per setting
    for (int b = 0; b < 2; b++) begin
      for (int k = 0; k < 4; k++) begin
        arr_valid <= 1'b1;
        arr_data  <= 16'hA5A0 | 16'(k);
        @(negedge clk);
        while (arr_ready !== 1'b1) @(negedge clk);
        @(posedge clk);
      end
      arr_valid <= 1'b0;
      arr_data  <= 16'h5A5F;
      @(negedge clk);
      chk(arr_ready, 1'b0);
      @(posedge clk);
      burst(b ? 16'h5D09 : 16'h5809, 23'h40, 1'b0);
      for (int k = 0; k < 4; k++) chk(dq[k], 16'hA5A0 | 16'(k));
      chk(arr_ready, 1'b1);
      chk(wait_out, !b[0]);
      chk(t_data - t_wait, b ? 1 : 0);
      chk(t_data, 6);
    end
    wrap_up();
  end
endmodule : tb
